// [igr_defs.svh]
// Constants of the global interrupt-controller register slice.
// Assumes inclusion by bare name from the package and the design module.
`ifndef IGR_DEFS_SVH
`define IGR_DEFS_SVH

// Register byte offsets.
`define IGR_OFS_VERSION 12'h000
`define IGR_OFS_CTRL 12'h004
`define IGR_OFS_GLOBAL_ON 12'h010
`define IGR_OFS_NEST 12'h01C
`define IGR_OFS_STS_SET 12'h020
`define IGR_OFS_STS_CLR 12'h024
`define IGR_OFS_EN_SET 12'h028
`define IGR_OFS_EVT_STATUS 12'h040
`define IGR_OFS_EVT_MASK 12'h044
`define IGR_OFS_PRI_INDEX 12'h080
`define IGR_OFS_PRI_VECTOR 12'h084

// Field positions.
`define IGR_CTRL_FREEZE_BIT 4
`define IGR_CTRL_NEST_LSB 2
`define IGR_NEST_OVR_BIT 31
`define IGR_NEST_LVL_MSB 8
`define IGR_INDEX_MSB 6
`define IGR_PRI_NONE_BIT 31
`define IGR_EVT_SOURCE_BIT 0
`define IGR_EVT_NEST_BIT 1
`define IGR_EVT_HOST_BIT 2
`define IGR_EVT_W 3

// Sizes.
`define IGR_NUM_SRC 128
`define IGR_NUM_HOST 2

// Reset values.
`define IGR_GLOBAL_ON_RST 1'h0
`define IGR_NEST_LVL_RST 9'h1FF
`define IGR_EVT_MASK_RST 3'h0
// Arbitrary version value.
`define IGR_VERSION_VALUE 32'h0001_0000

// Bus answers.
`define IGR_RESP_OKAY 2'h0
`define IGR_RESP_SLVERR 2'h2

`endif

// [igr_pkg.sv]
// Types shared by the global interrupt-controller register slice.
// Assumes igr_defs.svh is available on the include path.
`default_nettype none
`include "igr_defs.svh"

package igr_pkg;

    typedef enum logic [1:0] {
        IGR_NEST_NONE,
        IGR_NEST_INDIV,
        IGR_NEST_GLOBAL,
        IGR_NEST_MANUAL
    } igr_nest_e;

    typedef struct packed {
        logic priFreeze;
        igr_nest_e nestScheme;
    } igr_ctrl_s;

    typedef struct packed {
        logic none;
        logic [9:0] index;
        logic [31:0] vector;
    } igr_pri_s;

    typedef struct packed {
        logic req;
        logic enable;
        logic [`IGR_NEST_LVL_MSB:0] chan;
    } igr_host_req_s;

    typedef struct packed {
        logic valid;
        logic [`IGR_NEST_LVL_MSB:0] chan;
    } igr_nest_evt_s;

endpackage : igr_pkg

`default_nettype wire

// [igr_global_regs.sv]
// Global control and indexed-access register slice of a host interrupt controller.
// Assumes one clock, an AXI4-Lite master, and a prioritizer on the same clock.
`default_nettype none
`include "igr_defs.svh"

module igr_global_regs #(
    parameter logic [31:0] VERSION_WORD = `IGR_VERSION_VALUE
) (
    // Clock, reset and clock enable.
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // AXI4-Lite write channels.
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read channels.
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Interrupt sources from outside the clock domain.
    input wire logic [`IGR_NUM_SRC-1:0] srcIrq,
    // Prioritizer results and nesting events.
    input wire igr_pkg::igr_pri_s priIn,
    input wire igr_pkg::igr_host_req_s [`IGR_NUM_HOST-1:0] hostReq,
    input wire igr_pkg::igr_nest_evt_s nestEvt,
    // Held state towards the rest of the controller.
    output logic [`IGR_NUM_SRC-1:0] rawStatus,
    output logic [`IGR_NUM_SRC-1:0] srcEnable,
    output igr_pkg::igr_ctrl_s ctrl,
    output logic [`IGR_NEST_LVL_MSB:0] nestLevel,
    // Host outputs and block interrupt.
    output logic [`IGR_NUM_HOST-1:0] hostIrq,
    output logic irq
);

    logic [1:0] rstPipe_reg;
    logic rstSync_n;
    logic awHeld_reg;
    logic wHeld_reg;
    logic [11:0] awAddr_reg;
    logic [31:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic wrFire;
    logic arFire;
    logic [31:0] strbMask;
    logic [31:0] readMux;
    logic readHit;
    logic writeHit;
    logic [`IGR_INDEX_MSB:0] wrIndex;
    logic idxLane;
    igr_pkg::igr_ctrl_s ctrl_reg;
    logic globalOn_reg;
    logic [`IGR_NEST_LVL_MSB:0] nestLevel_reg;
    logic [`IGR_NEST_LVL_MSB:0] nestMerge;
    logic nestWrite;
    logic nestAuto;
    logic [`IGR_NUM_SRC-1:0] srcMeta_reg;
    logic [`IGR_NUM_SRC-1:0] srcSync_reg;
    logic [`IGR_NUM_SRC-1:0] srcLast_reg;
    logic [`IGR_NUM_SRC-1:0] srcRise;
    logic [`IGR_NUM_SRC-1:0] rawStatus_reg;
    logic [`IGR_NUM_SRC-1:0] rawStatus_next;
    logic [`IGR_NUM_SRC-1:0] srcEnable_reg;
    igr_pkg::igr_pri_s pri_reg;
    logic frozen_reg;
    logic firstIdx_reg;
    logic rdPriIdx;
    logic rdPriVec;
    logic [`IGR_NUM_HOST-1:0] hostIrq_reg;
    logic [`IGR_NUM_HOST-1:0] hostIrq_next;
    logic [`IGR_NUM_HOST-1:0] hostBlocked;
    logic [`IGR_EVT_W-1:0] evtStatus_reg;
    logic [`IGR_EVT_W-1:0] evtMask_reg;
    logic [`IGR_EVT_W-1:0] evtSet;
    logic [`IGR_EVT_W-1:0] evtClr;
    logic irq_reg;

    // Reset release through two flip-flops.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstPipe_reg <= 2'h0;
        end else begin
            rstPipe_reg <= {rstPipe_reg[0], 1'h1};
        end
    end
    assign rstSync_n = rstPipe_reg[1];

    // Bus handshakes and decode.
    assign awready = ce && !awHeld_reg && !bvalid_reg;
    assign wready = ce && !wHeld_reg && !bvalid_reg;
    assign arready = ce && !rvalid_reg;
    assign wrFire = ce && awHeld_reg && wHeld_reg && !bvalid_reg;
    assign arFire = ce && arvalid && arready;
    assign strbMask = {{8{wStrb_reg[3]}}, {8{wStrb_reg[2]}}, {8{wStrb_reg[1]}}, {8{wStrb_reg[0]}}};
    assign wrIndex = wData_reg[`IGR_INDEX_MSB:0];
    assign idxLane = wrFire && wStrb_reg[0];

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            awHeld_reg <= 1'h0;
            wHeld_reg <= 1'h0;
            awAddr_reg <= 12'h000;
            wData_reg <= 32'h0000_0000;
            wStrb_reg <= 4'h0;
            bvalid_reg <= 1'h0;
            bresp_reg <= `IGR_RESP_OKAY;
        end else if (ce) begin
            if (awvalid && awready) begin
                awHeld_reg <= 1'h1;
                awAddr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                wHeld_reg <= 1'h1;
                wData_reg <= wdata;
                wStrb_reg <= wstrb;
            end
            if (wrFire) begin
                awHeld_reg <= 1'h0;
                wHeld_reg <= 1'h0;
                bvalid_reg <= 1'h1;
                bresp_reg <= writeHit ? `IGR_RESP_OKAY : `IGR_RESP_SLVERR;
            end else if (bready) begin
                bvalid_reg <= 1'h0;
            end
        end
    end

    always_comb begin
        case (awAddr_reg)
            `IGR_OFS_VERSION, `IGR_OFS_CTRL, `IGR_OFS_GLOBAL_ON, `IGR_OFS_NEST,
            `IGR_OFS_STS_SET, `IGR_OFS_STS_CLR, `IGR_OFS_EN_SET, `IGR_OFS_EVT_STATUS,
            `IGR_OFS_EVT_MASK, `IGR_OFS_PRI_INDEX, `IGR_OFS_PRI_VECTOR: writeHit = 1'h1;
            default: writeHit = 1'h0;
        endcase
    end

    // Read mux; write-only ports and reserved bits read zero.
    always_comb begin
        readMux = 32'h0000_0000;
        readHit = 1'h1;
        case (araddr)
            `IGR_OFS_VERSION: readMux = VERSION_WORD;
            `IGR_OFS_CTRL: begin
                readMux[`IGR_CTRL_FREEZE_BIT] = ctrl_reg.priFreeze;
                readMux[`IGR_CTRL_NEST_LSB +: 2] = ctrl_reg.nestScheme;
            end
            `IGR_OFS_GLOBAL_ON: readMux[0] = globalOn_reg;
            `IGR_OFS_NEST: readMux[`IGR_NEST_LVL_MSB:0] = nestLevel_reg;
            `IGR_OFS_STS_SET, `IGR_OFS_STS_CLR, `IGR_OFS_EN_SET: readMux = 32'h0000_0000;
            `IGR_OFS_EVT_STATUS: readMux[`IGR_EVT_W-1:0] = evtStatus_reg;
            `IGR_OFS_EVT_MASK: readMux[`IGR_EVT_W-1:0] = evtMask_reg;
            `IGR_OFS_PRI_INDEX: begin
                readMux[`IGR_PRI_NONE_BIT] = pri_reg.none;
                readMux[9:0] = pri_reg.index;
            end
            `IGR_OFS_PRI_VECTOR: readMux = pri_reg.vector;
            default: readHit = 1'h0;
        endcase
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            rvalid_reg <= 1'h0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `IGR_RESP_OKAY;
        end else if (ce) begin
            if (arFire) begin
                rvalid_reg <= 1'h1;
                rdata_reg <= readMux;
                rresp_reg <= readHit ? `IGR_RESP_OKAY : `IGR_RESP_SLVERR;
            end else if (rready) begin
                rvalid_reg <= 1'h0;
            end
        end
    end

    // Control and global on registers; version word ignores writes.
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            ctrl_reg <= '{priFreeze: 1'h0, nestScheme: igr_pkg::IGR_NEST_NONE};
            globalOn_reg <= `IGR_GLOBAL_ON_RST;
        end else if (ce && idxLane) begin
            if (awAddr_reg == `IGR_OFS_CTRL) begin
                ctrl_reg.priFreeze <= wData_reg[`IGR_CTRL_FREEZE_BIT];
                ctrl_reg.nestScheme <= igr_pkg::igr_nest_e'(wData_reg[`IGR_CTRL_NEST_LSB +: 2]);
            end
            if (awAddr_reg == `IGR_OFS_GLOBAL_ON) begin
                globalOn_reg <= wData_reg[0];
            end
        end
    end

    // Nest level: override write, plain write outside global auto, else auto update.
    assign nestMerge = (nestLevel_reg & ~strbMask[`IGR_NEST_LVL_MSB:0])
        | (wData_reg[`IGR_NEST_LVL_MSB:0] & strbMask[`IGR_NEST_LVL_MSB:0]);
    assign nestWrite = wrFire && (awAddr_reg == `IGR_OFS_NEST)
        && ((wStrb_reg[3] && wData_reg[`IGR_NEST_OVR_BIT])
        || ctrl_reg.nestScheme != igr_pkg::IGR_NEST_GLOBAL);
    assign nestAuto = !nestWrite && nestEvt.valid
        && ctrl_reg.nestScheme == igr_pkg::IGR_NEST_GLOBAL;

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            nestLevel_reg <= `IGR_NEST_LVL_RST;
        end else if (ce) begin
            if (nestWrite) begin
                nestLevel_reg <= nestMerge;
            end else if (nestAuto) begin
                nestLevel_reg <= nestEvt.chan;
            end
        end
    end

    // Source synchroniser and rising-edge detection.
    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            srcMeta_reg <= '0;
            srcSync_reg <= '0;
            srcLast_reg <= '0;
        end else if (ce) begin
            srcMeta_reg <= srcIrq;
            srcSync_reg <= srcMeta_reg;
            srcLast_reg <= srcSync_reg;
        end
    end
    assign srcRise = srcSync_reg & ~srcLast_reg;

    // Raw status: a source edge or indexed set wins over an indexed clear.
    always_comb begin
        rawStatus_next = rawStatus_reg;
        if (idxLane && awAddr_reg == `IGR_OFS_STS_CLR) begin
            rawStatus_next[wrIndex] = 1'h0;
        end
        rawStatus_next = rawStatus_next | srcRise;
        if (idxLane && awAddr_reg == `IGR_OFS_STS_SET) begin
            rawStatus_next[wrIndex] = 1'h1;
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            rawStatus_reg <= '0;
            srcEnable_reg <= '0;
        end else if (ce) begin
            rawStatus_reg <= rawStatus_next;
            if (idxLane && awAddr_reg == `IGR_OFS_EN_SET) begin
                srcEnable_reg[wrIndex] <= 1'h1;
            end
        end
    end

    // Prioritized index and vector with optional hold after the first read.
    assign rdPriIdx = arFire && araddr == `IGR_OFS_PRI_INDEX;
    assign rdPriVec = arFire && araddr == `IGR_OFS_PRI_VECTOR;

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            frozen_reg <= 1'h0;
            firstIdx_reg <= 1'h0;
        end else if (ce) begin
            if (!ctrl_reg.priFreeze) begin
                frozen_reg <= 1'h0;
            end else if (!frozen_reg && (rdPriIdx || rdPriVec)) begin
                frozen_reg <= 1'h1;
                firstIdx_reg <= rdPriIdx;
            end else if (firstIdx_reg ? rdPriVec : rdPriIdx) begin
                frozen_reg <= 1'h0;
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            pri_reg <= '{none: 1'h1, index: 10'h000, vector: 32'h0000_0000};
        end else if (ce && !frozen_reg
            && !(ctrl_reg.priFreeze && (rdPriIdx || rdPriVec))) begin
            pri_reg <= priIn;
        end
    end

    // Host outputs: global on, individual enable and global nesting block.
    always_comb begin
        for (int h = 0; h < `IGR_NUM_HOST; h++) begin
            hostBlocked[h] = ctrl_reg.nestScheme == igr_pkg::IGR_NEST_GLOBAL
                && hostReq[h].chan >= nestLevel_reg;
            hostIrq_next[h] = hostReq[h].req && hostReq[h].enable
                && globalOn_reg && !hostBlocked[h];
        end
    end

    // Event status, mask and interrupt line.
    assign evtSet = {|(hostIrq_next & ~hostIrq_reg), nestAuto, |srcRise};
    assign evtClr = (idxLane && awAddr_reg == `IGR_OFS_EVT_STATUS)
        ? wData_reg[`IGR_EVT_W-1:0] : `IGR_EVT_W'(0);

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            hostIrq_reg <= '0;
            evtStatus_reg <= '0;
            evtMask_reg <= `IGR_EVT_MASK_RST;
            irq_reg <= 1'h0;
        end else if (ce) begin
            hostIrq_reg <= hostIrq_next;
            evtStatus_reg <= (evtStatus_reg & ~evtClr) | evtSet;
            if (idxLane && awAddr_reg == `IGR_OFS_EVT_MASK) begin
                evtMask_reg <= wData_reg[`IGR_EVT_W-1:0];
            end
            irq_reg <= |(((evtStatus_reg & ~evtClr) | evtSet) & evtMask_reg);
        end
    end

    // Outputs.
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;
    assign rawStatus = rawStatus_reg;
    assign srcEnable = srcEnable_reg;
    assign ctrl = ctrl_reg;
    assign nestLevel = nestLevel_reg;
    assign hostIrq = hostIrq_reg;
    assign irq = irq_reg;

    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSync_n);

    chk_version_fixed: assert property (
        arFire && araddr == `IGR_OFS_VERSION |=> rvalid && rdata == VERSION_WORD)
        else $error("Version word read wrong value.");
    chk_index_follow: assert property (
        ce && !ctrl_reg.priFreeze && !frozen_reg |=> pri_reg == $past(priIn))
        else $error("Prioritized value did not follow input.");
    chk_index_hold: assert property (
        ce && frozen_reg ##1 ce && frozen_reg |=> $stable(pri_reg) && pri_reg == $past(pri_reg, 2))
        else $error("Prioritized value changed while held.");
    chk_ctrl_store: assert property (
        idxLane && awAddr_reg == `IGR_OFS_CTRL
        |=> ctrl_reg.nestScheme == $past(wData_reg[`IGR_CTRL_NEST_LSB +: 2])
            && bvalid)
        else $error("Nesting field not stored.");
    chk_global_read: assert property (
        arFire && araddr == `IGR_OFS_GLOBAL_ON |=> rdata == {31'h0, $past(globalOn_reg)})
        else $error("Global on readback wrong.");
    chk_global_gate: assert property (
        ce && (!globalOn_reg || !hostReq[0].enable) |=> !hostIrq[0])
        else $error("Host output raised without enables.");
    chk_override_load: assert property (
        wrFire && awAddr_reg == `IGR_OFS_NEST && wStrb_reg == 4'hF
            && wData_reg[`IGR_NEST_OVR_BIT]
        |=> nestLevel_reg == $past(wData_reg[`IGR_NEST_LVL_MSB:0]))
        else $error("Override write did not load nest level.");
    chk_nest_auto: assert property (
        nestAuto && ce |=> nestLevel_reg == $past(nestEvt.chan) && evtStatus_reg[1])
        else $error("Automatic nest update missing.");
    chk_nest_block: assert property (
        ce && ctrl_reg.nestScheme == igr_pkg::IGR_NEST_GLOBAL
            && hostReq[1].chan >= nestLevel_reg |=> !hostIrq[1])
        else $error("Nested channel reached host output.");
    chk_status_set: assert property (
        idxLane && awAddr_reg == `IGR_OFS_STS_SET
        |=> rawStatus_reg[$past(wrIndex)] ##1 !bvalid || rawStatus_reg != 0)
        else $error("Indexed set did not set raw status.");
    chk_status_clear: assert property (
        idxLane && awAddr_reg == `IGR_OFS_STS_CLR && !srcRise[wrIndex]
        |=> !rawStatus_reg[$past(wrIndex)])
        else $error("Indexed clear did not clear raw status.");
    chk_enable_set: assert property (
        idxLane && awAddr_reg == `IGR_OFS_EN_SET
        |=> srcEnable_reg == ($past(srcEnable_reg) | (`IGR_NUM_SRC'(1) << $past(wrIndex))))
        else $error("Indexed enable set wrong.");
    chk_reserved_zero: assert property (
        arFire && araddr == `IGR_OFS_CTRL |=> rdata[31:5] == 27'h0 && rdata[1:0] == 2'h0)
        else $error("Reserved control bits read nonzero.");

    cov_status_set: cover property (idxLane && awAddr_reg == `IGR_OFS_STS_SET);
    cov_hold_read: cover property (frozen_reg && rdPriVec);
    cov_nest_block: cover property (ce && hostReq[0].req && hostBlocked[0] && globalOn_reg);
    cov_irq_raise: cover property (!irq ##1 irq);

endmodule : igr_global_regs

`default_nettype wire

// [igr_far_model.sv]
// Far-side model: prioritizer and host core beside the register slice.
// Assumes the slice's registered raw status and enables on the same clock.
`default_nettype none
`include "igr_defs.svh"

module igr_far_model (
    // Clock and nest entry request from the bench.
    input wire logic clk,
    input wire logic enterNest,
    // State from the slice.
    input wire logic [`IGR_NUM_SRC-1:0] rawStatus,
    input wire logic [`IGR_NUM_SRC-1:0] srcEnable,
    // Results towards the slice.
    output igr_pkg::igr_pri_s priIn,
    output igr_pkg::igr_host_req_s [`IGR_NUM_HOST-1:0] hostReq,
    output igr_pkg::igr_nest_evt_s nestEvt
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [`IGR_NUM_SRC-1:0] pend;
    int idx;
    // The lowest pending enabled number wins; host 1 never has its own enable.
    always_comb begin
        pend = rawStatus & srcEnable;
        idx = 0;
        for (int i = `IGR_NUM_SRC - 1; i >= 0; i--) begin
            if (pend[i]) begin
                idx = i;
            end
        end
    end
    always_ff @(posedge clk) begin
        priIn <= {pend == '0, 10'(idx), 32'h0000_1000 + 32'(idx) * 32'h4};
        hostReq[0] <= {pend != '0, 1'b1, 9'(idx)};
        hostReq[1] <= {pend != '0, 1'b0, 9'(idx)};
        nestEvt <= {enterNest, 9'(idx)};
    end
endmodule : igr_far_model

`default_nettype wire

// [irq_controller_global_regs_tb.sv]
// Self-checking bench for the global register slice over AXI4-Lite.
// Assumes the far-side model file and the design package are compiled first.
`default_nettype none
`include "igr_defs.svh"

module irq_controller_global_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, arst_n, ce, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, irq, enterNest;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, hostIrq;
    logic [127:0] srcIrq, rawStatus, srcEnable;
    logic [8:0] nestLevel;
    igr_pkg::igr_pri_s priIn;
    igr_pkg::igr_host_req_s [1:0] hostReq;
    igr_pkg::igr_nest_evt_s nestEvt;
    igr_pkg::igr_ctrl_s ctrl;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    localparam logic [1:0] OK = `IGR_RESP_OKAY;
    localparam logic [1:0] ERR = `IGR_RESP_SLVERR;

    igr_global_regs dut_u (.clk(clk), .arst_n(arst_n), .ce(ce), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
        .rready(rready), .rdata(rdata), .rresp(rresp), .srcIrq(srcIrq), .priIn(priIn),
        .hostReq(hostReq), .nestEvt(nestEvt), .rawStatus(rawStatus),
        .srcEnable(srcEnable), .ctrl(ctrl), .nestLevel(nestLevel), .hostIrq(hostIrq),
        .irq(irq));
    igr_far_model far_u (.clk(clk), .enterNest(enterNest), .rawStatus(rawStatus),
        .srcEnable(srcEnable),
        .priIn(priIn), .hostReq(hostReq), .nestEvt(nestEvt));

    always #25 clk = ~clk;

    task automatic give_verdict();
        $display("Errors %0d, comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) begin
                awvalid <= 1'b0;
            end
            if (wready) begin
                wvalid <= 1'b0;
            end
        end while (bvalid !== 1'b1);
        chk({30'h0, bresp}, {30'h0, er});
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) begin
                arvalid <= 1'b0;
            end
        end while (rvalid !== 1'b1);
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, er});
    endtask : rd

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end

    initial begin
        clk = 1'b0;
        arst_n = 1'b0;
        ce = 1'b1;
        enterNest = 1'b0;
        wstrb = 4'hF;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 12'h000;
        araddr = 12'h000;
        wdata = 32'h0000_0000;
        srcIrq = '0;
        cyc(5);
        arst_n <= 1'b1;
        cyc(3);
        rd(12'h000, `IGR_VERSION_VALUE, OK);
        wr(12'h000, 32'hFFFF_FFFF, OK);
        rd(12'h000, `IGR_VERSION_VALUE, OK);
        rd(12'h01C, 32'h0000_01FF, OK);
        rd(12'h010, 32'h0000_0000, OK);
        for (int m = 0; m < 4; m++) begin
            wr(12'h004, {27'h7FF_FFFF, 1'b1, 2'(m), 2'h3}, OK);
            rd(12'h004, {27'h0, 1'b1, 2'(m), 2'h0}, OK);
            chk({30'h0, ctrl.nestScheme}, 32'(m));
        end
        wr(12'h004, 32'h0000_0000, OK);
        wr(12'h010, 32'hFFFF_FFFF, OK);
        rd(12'h010, 32'h0000_0001, OK);
        wr(12'h010, 32'hFFFF_FFFE, OK);
        rd(12'h010, 32'h0000_0000, OK);
        wr(12'h01C, 32'h7FFF_FE05, OK);
        rd(12'h01C, 32'h0000_0005, OK);
        wr(12'h01C, 32'h8000_0003, OK);
        rd(12'h01C, 32'h0000_0003, OK);
        chk({23'h0, nestLevel}, 32'h0000_0003);
        wr(12'h020, 32'hFFFF_FF80, OK);
        wr(12'h020, 32'h0000_007F, OK);
        chk({30'h0, rawStatus[127], rawStatus[0]}, 32'h3);
        rd(12'h020, 32'h0000_0000, OK);
        wr(12'h024, 32'h0000_007F, OK);
        chk({30'h0, rawStatus[127], rawStatus[0]}, 32'h1);
        rd(12'h024, 32'h0000_0000, OK);
        wr(12'h028, 32'h0000_0000, OK);
        chk({30'h0, srcEnable[1:0]}, 32'h1);
        rd(12'h028, 32'h0000_0000, OK);
        cyc(4);
        chk({30'h0, hostIrq}, 32'h0);
        wr(12'h010, 32'h0000_0001, OK);
        cyc(4);
        chk({30'h0, hostIrq}, 32'h1);
        rd(12'h080, 32'h0000_0000, OK);
        rd(12'h084, 32'h0000_1000, OK);
        wr(12'h028, 32'h0000_0001, OK);
        wr(12'h020, 32'h0000_0001, OK);
        wr(12'h004, 32'h0000_0010, OK);
        rd(12'h080, 32'h0000_0000, OK);
        wr(12'h024, 32'h0000_0000, OK);
        cyc(4);
        rd(12'h084, 32'h0000_1000, OK);
        wr(12'h004, 32'h0000_0000, OK);
        cyc(3);
        rd(12'h080, 32'h0000_0001, OK);
        wr(12'h004, 32'h0000_0008, OK);
        wr(12'h01C, 32'h8000_0001, OK);
        cyc(4);
        chk({30'h0, hostIrq}, 32'h0);
        wr(12'h01C, 32'h8000_0002, OK);
        wr(12'h01C, 32'h0000_0007, OK);
        rd(12'h01C, 32'h0000_0002, OK);
        cyc(3);
        chk({30'h0, hostIrq}, 32'h1);
        wr(12'h028, 32'h0000_0014, OK);
        enterNest <= 1'b1;
        cyc(1);
        enterNest <= 1'b0;
        cyc(3);
        chk({23'h0, nestLevel}, 32'h0000_0001);
        chk({30'h0, hostIrq}, 32'h0);
        wr(12'h0FC, 32'hFFFF_FFFF, ERR);
        rd(12'h0FC, 32'h0000_0000, ERR);
        wr(12'h044, 32'h0000_0000, OK);
        srcIrq[9] <= 1'b1;
        cyc(6);
        chk({31'h0, rawStatus[9]}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(12'h044, 32'h0000_0001, OK);
        cyc(3);
        chk({31'h0, irq}, 32'h1);
        wr(12'h040, 32'h0000_0001, OK);
        cyc(3);
        chk({31'h0, irq}, 32'h0);
        ce <= 1'b0;
        srcIrq[20] <= 1'b1;
        cyc(6);
        chk({31'h0, rawStatus[20]}, 32'h0);
        ce <= 1'b1;
        cyc(6);
        chk({31'h0, rawStatus[20]}, 32'h1);
        give_verdict();
    end
endmodule : irq_controller_global_regs_tb

`default_nettype wire
